// ---- design/gpio_xbar_pkg.sv ----
package gpio_xbar_pkg;

  localparam int NUM_PORTS = 4;
  localparam int NUM_PINS  = 32;
  localparam int NUM_FUNCS = 8;

  // register byte offsets
  localparam logic [7:0] OFS_PORT_DATA   = 8'h00; // 0x00..0x0C, pins
  localparam logic [7:0] OFS_OUT_MODE    = 8'h10; // 0x10..0x1C
  localparam logic [7:0] OFS_P1_IN_MODE  = 8'h20;
  localparam logic [7:0] OFS_P3_EDGE_IRQ = 8'h24;
  localparam logic [7:0] OFS_XBAR_CFG0   = 8'h28;
  localparam logic [7:0] OFS_XBAR_CFG2   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h30;
  localparam logic [7:0] OFS_LATCH_READ  = 8'h40; // 0x40..0x4C, latches

  // reset values
  localparam logic [7:0] PORT_DATA_RST = 8'hFF;
  localparam logic [7:0] OUT_MODE_RST  = 8'h00;
  localparam logic [7:0] IN_MODE_RST   = 8'hFF;
  localparam logic [7:0] XBAR_CFG_RST  = 8'h00;

  // field positions
  localparam int PULLUP_OFF_BIT  = 7;
  localparam int XBAR_ON_BIT     = 6;
  localparam int MEMIF_LO_BIT    = 1;
  localparam int SERIAL0_EN_BIT  = 2;
  localparam int SPI_EN_BIT      = 1;
  localparam int TWOWIRE_EN_BIT  = 0;
  localparam int POL_A_BIT       = 2;
  localparam int POL_B_BIT       = 3;
  localparam int FLAG_A_BIT      = 6;
  localparam int FLAG_B_BIT      = 7;

  // pin positions
  localparam int WR_STROBE_PIN  = 7;
  localparam int RD_STROBE_PIN  = 6;
  localparam int ALE_PIN        = 5;
  localparam int PORT1_BASE     = 8;
  localparam int EDGE_A_PIN     = 30;
  localparam int EDGE_B_PIN     = 31;

  // crossbar functions in priority order
  localparam logic [3:0] FN_TX   = 4'h0;
  localparam logic [3:0] FN_RX   = 4'h1;
  localparam logic [3:0] FN_SCK  = 4'h2;
  localparam logic [3:0] FN_MISO = 4'h3;
  localparam logic [3:0] FN_MOSI = 4'h4;
  localparam logic [3:0] FN_NSS  = 4'h5;
  localparam logic [3:0] FN_SDA  = 4'h6;
  localparam logic [3:0] FN_SCL  = 4'h7;
  localparam logic [3:0] FN_NONE = 4'hF;

  typedef struct packed {
    logic tx;
    logic sck;
    logic miso;
    logic mosi;
    logic sda;
    logic scl;
  } periph_out_t;

  typedef struct packed {
    logic rx;
    logic sck;
    logic miso;
    logic mosi;
    logic nss;
    logic sda;
    logic scl;
  } periph_in_t;

  typedef struct packed {
    logic        active;
    logic        muxed;
    logic        readXfer;
    logic [31:0] ctrlMask;
    logic [31:0] dataMask;
    logic [31:0] value;
  } memif_t;

endpackage

// ---- design/edge_irq_flags.sv ----
`timescale 1ns/1ns
`default_nettype none

module edge_irq_flags #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] lineIn,
  input  wire logic [W-1:0] risingSel,
  input  wire logic [W-1:0] clearReq,
  output logic      [W-1:0] flag
);

  logic [W-1:0] syncA;
  logic [W-1:0] syncB;
  logic [W-1:0] prev;
  logic [W-1:0] edgeSeen;
  logic [2:0]   warm;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncA <= '0;
      syncB <= '0;
      prev  <= '0;
      warm  <= 3'h0;
    end else begin
      syncA <= lineIn;
      syncB <= syncA;
      prev  <= syncB;
      warm  <= {warm[1:0], 1'b1};
    end
  end

  // rising when the polarity bit is one, falling otherwise
  // held off until the pipe holds real levels, else reset zeros fake a rise
  assign edgeSeen = {W{warm[2]}}
                  & ((risingSel & syncB & ~prev)
                  | (~risingSel & ~syncB & prev));

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~clearReq) | edgeSeen;
    end
  end

endmodule

`default_nettype wire

// ---- design/port_pin_config.sv ----
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - open-drain pin with latch one leaves driver off; pin is sampled
// - pins routed to peripheral inputs get their drivers disabled
// - port 3 pins 6 and 7 are edge interrupts; polarity bits 2 and 3
// - a selected edge sets that pin's flag in the edge irq register
// - a set flag with its enable on raises an interrupt request
// - all weak pull-ups are on after reset
// - global pull-up off bit 7 of crossbar config 2 kills all pull-ups
// - a pin driving zero has its pull-up switched off
// - port 1 input-mode bit zero makes that pin analog
// - port 1 input-mode register resets to all ones
// - analog pins read back zero
// - analog pins have their pull-up off regardless of global bit
// - crossbar skips analog pins and moves to the next eligible pin
// - memory interface on low ports reserves strobes, and ALE if muxed
// - memory transfer overrides crossbar and latch on affected pins
// - transfers keep output modes; reads turn off data bus drivers
// - crossbar priority: serial0, then spi, then two-wire
// - all drivers stay off until the crossbar enable bit is set
// - output mode one is push-pull, zero open-drain, reset open-drain
module port_pin_config (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic [7:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire logic [31:0]               pinIn,
  output logic      [31:0]               pinOut,
  output logic      [31:0]               pinOe,
  output logic      [31:0]               pullupOn,
  input  wire gpio_xbar_pkg::periph_out_t periphOut,
  output gpio_xbar_pkg::periph_in_t      periphIn,
  input  wire logic                      spiMaster,
  input  wire gpio_xbar_pkg::memif_t     memif,
  output logic      [7:0]                analogMode,
  output logic      [1:0]                edgeIrqReq
);

  logic [7:0]  portData [gpio_xbar_pkg::NUM_PORTS];
  logic [7:0]  outMode [gpio_xbar_pkg::NUM_PORTS];
  logic [7:0]  inMode;
  logic [1:0]  edgePol;
  logic [1:0]  edgeEn;
  logic [1:0]  edgeFlag;
  logic [1:0]  edgeClear;
  logic [7:0]  xbarCfg0;
  logic [7:0]  xbarCfg2;
  logic [31:0] pinSyncA;
  logic [31:0] pinSync;
  logic        ack;
  logic        wrDone;
  logic [31:0] latchFlat;
  logic [31:0] modeFlat;
  logic [31:0] skip;
  logic [7:0]  funcEn;
  logic [3:0]  funcList [gpio_xbar_pkg::NUM_FUNCS];
  logic [3:0]  pinFunc [gpio_xbar_pkg::NUM_PINS];
  logic [7:0]  fnIn;
  logic [31:0] next_pinOut;
  logic [31:0] next_pinOe;
  logic [31:0] next_pullupOn;
  logic [31:0] digitalMask;
  logic        xbarOn;
  logic        memifLo;
  logic [7:0]  next_readdata;

  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] base);
    regHit = (addr == base);
  endfunction

  function automatic logic bankHit(input logic [7:0] addr,
                                   input logic [7:0] base);
    bankHit = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
  endfunction

  assign xbarOn  = xbarCfg2[gpio_xbar_pkg::XBAR_ON_BIT];
  assign memifLo = xbarCfg2[gpio_xbar_pkg::MEMIF_LO_BIT];

  // one wait cycle per access; answer on the second edge
  assign waitrequest = (read | write) & ~ack;
  assign wrDone      = write & ack & byteenable[0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // pin sampling; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinSyncA <= '0;
      pinSync  <= '0;
    end else begin
      pinSyncA <= pinIn;
      pinSync  <= pinSyncA;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < gpio_xbar_pkg::NUM_PORTS; i++) begin
        portData[i] <= gpio_xbar_pkg::PORT_DATA_RST;
        outMode[i]  <= gpio_xbar_pkg::OUT_MODE_RST;
      end
    end else if (wrDone) begin
      if (bankHit(address, gpio_xbar_pkg::OFS_PORT_DATA)) begin
        portData[address[3:2]] <= writedata[7:0];
      end else if (bankHit(address, gpio_xbar_pkg::OFS_OUT_MODE)) begin
        outMode[address[3:2]] <= writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      inMode   <= gpio_xbar_pkg::IN_MODE_RST;
      xbarCfg0 <= gpio_xbar_pkg::XBAR_CFG_RST;
      xbarCfg2 <= gpio_xbar_pkg::XBAR_CFG_RST;
      edgePol  <= 2'h0;
      edgeEn   <= 2'h0;
    end else if (wrDone) begin
      if (regHit(address, gpio_xbar_pkg::OFS_P1_IN_MODE)) begin
        inMode <= writedata[7:0];
      end else if (regHit(address, gpio_xbar_pkg::OFS_XBAR_CFG0)) begin
        xbarCfg0 <= writedata[7:0];
      end else if (regHit(address, gpio_xbar_pkg::OFS_XBAR_CFG2)) begin
        xbarCfg2 <= writedata[7:0];
      end else if (regHit(address, gpio_xbar_pkg::OFS_P3_EDGE_IRQ)) begin
        edgePol <= {writedata[gpio_xbar_pkg::POL_B_BIT],
                    writedata[gpio_xbar_pkg::POL_A_BIT]};
      end else if (regHit(address, gpio_xbar_pkg::OFS_IRQ_ENABLE)) begin
        edgeEn <= writedata[1:0];
      end
    end
  end

  // writing zero to a flag bit requests its clear
  always_comb begin
    edgeClear = 2'h0;
    if (wrDone && regHit(address, gpio_xbar_pkg::OFS_P3_EDGE_IRQ)) begin
      edgeClear = ~{writedata[gpio_xbar_pkg::FLAG_B_BIT],
                    writedata[gpio_xbar_pkg::FLAG_A_BIT]};
    end
  end

  edge_irq_flags #(
    .W(2)
  ) u_edge (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .lineIn   ({pinIn[gpio_xbar_pkg::EDGE_B_PIN],
                pinIn[gpio_xbar_pkg::EDGE_A_PIN]}),
    .risingSel(edgePol),
    .clearReq (edgeClear),
    .flag     (edgeFlag)
  );

  assign edgeIrqReq = edgeFlag & edgeEn;
  assign analogMode = ~inMode;

  always_comb begin
    for (int i = 0; i < gpio_xbar_pkg::NUM_PORTS; i++) begin
      latchFlat[i*8 +: 8] = portData[i];
      modeFlat[i*8 +: 8]  = outMode[i];
    end
    digitalMask = '1;
    digitalMask[gpio_xbar_pkg::PORT1_BASE +: 8] = inMode;
  end

  // crossbar: compact enabled functions, then deal them to free pins
  always_comb begin
    logic [3:0] n;
    logic [3:0] k;
    n = 4'h0;
    k = 4'h0;
    skip = '0;
    skip[gpio_xbar_pkg::PORT1_BASE +: 8] = ~inMode;
    if (memifLo) begin
      skip[gpio_xbar_pkg::WR_STROBE_PIN] = 1'b1;
      skip[gpio_xbar_pkg::RD_STROBE_PIN] = 1'b1;
      if (memif.muxed) begin
        skip[gpio_xbar_pkg::ALE_PIN] = 1'b1;
      end
    end
    funcEn = {{2{xbarCfg0[gpio_xbar_pkg::TWOWIRE_EN_BIT]}},
              {4{xbarCfg0[gpio_xbar_pkg::SPI_EN_BIT]}},
              {2{xbarCfg0[gpio_xbar_pkg::SERIAL0_EN_BIT]}}};
    for (int f = 0; f < gpio_xbar_pkg::NUM_FUNCS; f++) begin
      funcList[f] = gpio_xbar_pkg::FN_NONE;
    end
    for (int f = 0; f < gpio_xbar_pkg::NUM_FUNCS; f++) begin
      if (funcEn[f]) begin
        funcList[n[2:0]] = 4'(f);
        n = n + 4'h1;
      end
    end
    for (int p = 0; p < gpio_xbar_pkg::NUM_PINS; p++) begin
      pinFunc[p] = gpio_xbar_pkg::FN_NONE;
      if (!skip[p] && (k < n)) begin
        pinFunc[p] = funcList[k[2:0]];
        k = k + 4'h1;
      end
    end
  end

  // per-pin drive, direction and pull-up
  always_comb begin
    logic val;
    logic isIn;
    logic forceOd;
    logic drive;
    val = 1'b1;
    isIn = 1'b0;
    forceOd = 1'b0;
    drive = 1'b0;
    fnIn = '1;
    for (int p = 0; p < gpio_xbar_pkg::NUM_PINS; p++) begin
      val = latchFlat[p];
      isIn = 1'b0;
      forceOd = 1'b0;
      if (pinFunc[p] != gpio_xbar_pkg::FN_NONE) begin
        fnIn[pinFunc[p][2:0]] = pinSync[p];
      end
      case (pinFunc[p])
        gpio_xbar_pkg::FN_TX: begin
          val = periphOut.tx;
        end
        gpio_xbar_pkg::FN_RX: begin
          isIn = 1'b1;
        end
        gpio_xbar_pkg::FN_SCK: begin
          val = periphOut.sck;
          isIn = ~spiMaster;
        end
        gpio_xbar_pkg::FN_MISO: begin
          val = periphOut.miso;
          isIn = spiMaster;
        end
        gpio_xbar_pkg::FN_MOSI: begin
          val = periphOut.mosi;
          isIn = ~spiMaster;
        end
        gpio_xbar_pkg::FN_NSS: begin
          isIn = 1'b1;
        end
        gpio_xbar_pkg::FN_SDA: begin
          val = periphOut.sda;
          forceOd = 1'b1;
        end
        gpio_xbar_pkg::FN_SCL: begin
          val = periphOut.scl;
          forceOd = 1'b1;
        end
        default: begin
          val = latchFlat[p];
        end
      endcase
      // push-pull drives both levels, open-drain only a zero
      drive = ~isIn & ((modeFlat[p] & ~forceOd) | ~val);
      if (memifLo && memif.active && memif.ctrlMask[p]) begin
        val = memif.value[p];
        drive = modeFlat[p] | ~val;
        if (memif.readXfer && memif.dataMask[p]) begin
          drive = 1'b0;
        end
      end
      next_pinOut[p] = val;
      next_pinOe[p]  = xbarOn & drive;
      next_pullupOn[p] = ~xbarCfg2[gpio_xbar_pkg::PULLUP_OFF_BIT]
                       & digitalMask[p]
                       & ~(next_pinOe[p] & ~val);
    end
  end

  always_comb begin
    periphIn.rx   = fnIn[gpio_xbar_pkg::FN_RX[2:0]];
    periphIn.sck  = fnIn[gpio_xbar_pkg::FN_SCK[2:0]];
    periphIn.miso = fnIn[gpio_xbar_pkg::FN_MISO[2:0]];
    periphIn.mosi = fnIn[gpio_xbar_pkg::FN_MOSI[2:0]];
    periphIn.nss  = fnIn[gpio_xbar_pkg::FN_NSS[2:0]];
    periphIn.sda  = fnIn[gpio_xbar_pkg::FN_SDA[2:0]];
    periphIn.scl  = fnIn[gpio_xbar_pkg::FN_SCL[2:0]];
  end

  // registered pin drive avoids glitches from the crossbar decode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinOut   <= '1;
      pinOe    <= '0;
      pullupOn <= '1;
    end else begin
      pinOut   <= next_pinOut;
      pinOe    <= next_pinOe;
      pullupOn <= next_pullupOn;
    end
  end

  always_comb begin
    logic [31:0] pinView;
    pinView = pinSync & digitalMask;
    next_readdata = 8'h00;
    if (bankHit(address, gpio_xbar_pkg::OFS_PORT_DATA)) begin
      next_readdata = pinView[address[3:2]*8 +: 8];
    end else if (bankHit(address, gpio_xbar_pkg::OFS_LATCH_READ)) begin
      next_readdata = portData[address[3:2]];
    end else if (bankHit(address, gpio_xbar_pkg::OFS_OUT_MODE)) begin
      next_readdata = outMode[address[3:2]];
    end else if (regHit(address, gpio_xbar_pkg::OFS_P1_IN_MODE)) begin
      next_readdata = inMode;
    end else if (regHit(address, gpio_xbar_pkg::OFS_P3_EDGE_IRQ)) begin
      next_readdata[gpio_xbar_pkg::FLAG_A_BIT] = edgeFlag[0];
      next_readdata[gpio_xbar_pkg::FLAG_B_BIT] = edgeFlag[1];
      next_readdata[gpio_xbar_pkg::POL_A_BIT]  = edgePol[0];
      next_readdata[gpio_xbar_pkg::POL_B_BIT]  = edgePol[1];
    end else if (regHit(address, gpio_xbar_pkg::OFS_XBAR_CFG0)) begin
      next_readdata = xbarCfg0;
    end else if (regHit(address, gpio_xbar_pkg::OFS_XBAR_CFG2)) begin
      next_readdata = xbarCfg2;
    end else if (regHit(address, gpio_xbar_pkg::OFS_IRQ_ENABLE)) begin
      next_readdata = {6'h00, edgeEn};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      readdata <= {24'h00_0000, next_readdata};
    end
  end

endmodule

`default_nettype wire

// ---- test/pin_world.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_world (
  input  wire logic        sys_clk,
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOe,
  input  wire logic [31:0] pullupOn,
  input  wire logic [31:0] extEn,
  input  wire logic [31:0] extVal,
  output logic      [31:0] pinIn
);
  logic tog;
  // a floating pin wanders, so no stale level can pass for a real one
  always_ff @(posedge sys_clk) tog <= (tog === 1'b1) ? 1'b0 : 1'b1;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] :
                 pullupOn[i] ? 1'b1 : tog;
    end
  end
endmodule
`default_nettype wire

// ---- test/port_pin_config_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module port_pin_config_monitor (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic [7:0]            address,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  input  wire logic                  waitrequest,
  input  wire logic [31:0]           pinIn,
  input  wire logic [31:0]           pinOut,
  input  wire logic [31:0]           pinOe,
  input  wire logic [31:0]           pullupOn,
  input  wire gpio_xbar_pkg::memif_t memif,
  input  wire logic [7:0]            analogMode,
  input  wire logic [1:0]            edgeIrqReq
);
  logic [7:0] cfg0, cfg2, inMode, edgeCfg, irqEn;
  // shadow copies, since the checker sees no registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg0    <= 8'h00;
      cfg2    <= 8'h00;
      inMode  <= 8'hFF;
      edgeCfg <= 8'h00;
      irqEn   <= 8'h00;
    end else if (write && !waitrequest && byteenable[0]) begin
      case (address)
        8'h28: cfg0 <= writedata[7:0];
        8'h2C: cfg2 <= writedata[7:0];
        8'h20: inMode <= writedata[7:0];
        8'h24: edgeCfg <= writedata[7:0];
        8'h30: irqEn <= writedata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  reset_pins_a: assert property (
    $past(reset) |-> pullupOn == 32'hFFFFFFFF && pinOe == 32'h0)
    else $error("pins not at reset state");
  xbar_off_a: assert property (
    !cfg2[6] && !$past(cfg2[6]) |-> pinOe == 32'h0)
    else $error("driver on while crossbar off");
  pullup_global_a: assert property (
    cfg2[7] && $past(cfg2[7]) |-> pullupOn == 32'h0)
    else $error("pull-up on while globally off");
  pullup_low_a: assert property (
    (pinOe & ~pinOut) != 0 |-> (pinOe & ~pinOut & pullupOn) == 0)
    else $error("pull-up on a pin driving low");
  analog_pullup_a: assert property (
    analogMode != 0 && $stable(analogMode)
    |-> (pullupOn[15:8] & analogMode) == 8'h00)
    else $error("pull-up on an analog pin");
  analog_mode_a: assert property (analogMode == ~inMode)
    else $error("analog mode differs from input mode");
  rx_undriven_a: assert property (
    cfg0[2] && $past(cfg0[2]) && !memif.active |-> !pinOe[1])
    else $error("receive pin driven");
  edge_rise_a: assert property (
    edgeCfg[2] && irqEn[0] && $rose(pinIn[30]) |-> ##3 edgeIrqReq[0])
    else $error("rising edge not flagged");
  edge_fall_a: assert property (
    !edgeCfg[3] && irqEn[1] && $fell(pinIn[31]) |-> ##3 edgeIrqReq[1])
    else $error("falling edge not flagged");
  irq_gate_a: assert property (
    edgeIrqReq != 0 |-> (edgeIrqReq & ~irqEn[1:0]) == 2'b00)
    else $error("request without enable");
  cover property (edgeIrqReq == 2'b11);
  cover property (cfg2[7] && pullupOn == 32'h0);
  cover property (analogMode != 0 && pinOe[10]);
endmodule
bind port_pin_config port_pin_config_monitor mon (.sys_clk, .reset,
  .address, .write, .writedata, .byteenable, .waitrequest, .pinIn,
  .pinOut, .pinOe, .pullupOn, .memif, .analogMode, .edgeIrqReq);
`default_nettype wire

// ---- test/port_pin_config_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module port_pin_config_tb;
  logic        sys_clk, reset, read, write, waitrequest, spiMaster;
  logic [7:0]  address, analogMode;
  logic [31:0] writedata, readdata, pinIn, pinOut, pinOe, pullupOn;
  logic [31:0] extEn, extVal;
  logic [3:0]  byteenable;
  logic [1:0]  edgeIrqReq;
  gpio_xbar_pkg::periph_out_t periphOut;
  gpio_xbar_pkg::periph_in_t  periphIn;
  gpio_xbar_pkg::memif_t      memif;
  int n_fail = 0;
  int comparisons = 0;

  port_pin_config dut (.sys_clk, .reset, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .pinIn, .pinOut,
    .pinOe, .pullupOn, .periphOut, .periphIn, .spiMaster, .memif,
    .analogMode, .edgeIrqReq);
  pin_world far (.sys_clk, .pinOut, .pinOe, .pullupOn, .extEn, .extVal,
    .pinIn);

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic bus(input logic rd, input logic [7:0] a, d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= rd;
    write <= !rd;
    n = 0;
    #1;
    // look between edges so the level seen is the one the edge samples
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (waitrequest !== 1'b0) begin
      n_fail++;
      wrap_up;
    end
    @(posedge sys_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    chk(w, q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset;
    settle(1);
    chk("oe", pinOe, 32'h0);
    chk("out", pinOut, 32'hFFFFFFFF);
    chk("pullup", pullupOn, 32'hFFFFFFFF);
    rdc("inmode", 8'h20, 32'hFF);
    rdc("outmode", 8'h10, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    byteenable <= 4'hE;
    wr(8'h20, 8'h00);
    byteenable <= 4'hF;
    rdc("lane off", 8'h20, 32'hFF);
    $display("test reset done");
  endtask

  task automatic t_gpio;
    wr(8'h2C, 8'h40);
    wr(8'h10, 8'h0F);
    wr(8'h00, 8'hA5);
    extEn <= 32'hC0000020;
    extVal <= 32'hC0000000;
    settle(3);
    chk("oe0", pinOe, 32'h5F);
    chk("out0", pinOut[7:0], 32'hA5);
    chk("pu0", pullupOn[7:0], 32'hA5);
    rdc("pins0", 8'h00, 32'h85);
    rdc("latch0", 8'h40, 32'hA5);
    $display("test gpio done");
  endtask

  task automatic t_analog;
    extEn <= 32'hC000FF00;
    extVal <= 32'hC000FF00;
    wr(8'h20, 8'h0F);
    settle(3);
    chk("analog", analogMode, 32'hF0);
    chk("pu1", pullupOn[15:8], 32'h0F);
    rdc("pins1", 8'h04, 32'h0F);
    wr(8'h2C, 8'hC0);
    settle(2);
    chk("pu off", pullupOn, 32'h0);
    wr(8'h2C, 8'h40);
    $display("test analog done");
  endtask

  task automatic t_xbar;
    wr(8'h20, 8'hFE); // port 1 pin 0 made analog, so the crossbar skips pin 8
    wr(8'h00, 8'hFF);
    wr(8'h10, 8'hFF);
    wr(8'h28, 8'h07);
    wr(8'h2C, 8'h42);
    memif.muxed <= 1'b1;
    periphOut.tx <= 1'b0;
    periphOut.sda <= 1'b0;
    extEn <= 32'hC0000202;
    extVal <= 32'hC0000000;
    settle(4);
    chk("tx", {pinOe[0], pinOut[0]}, 32'h2);
    chk("rx oe", pinOe[1], 32'h0);
    chk("rx in", periphIn.rx, 32'h0);
    chk("nss in", periphIn.nss, 32'h0);
    chk("sda", {pinOe[10], pinOut[10]}, 32'h2);
    chk("strobes", pinOut[7:5], 32'h7);
    chk("spi oe", pinOe[4:2], 32'h5);
    @(posedge sys_clk);
    spiMaster <= 1'b0;
    settle(2);
    chk("spi slave oe", pinOe[4:2], 32'h2);
    wr(8'h2C, 8'h40);
    wr(8'h28, 8'h01);
    settle(2);
    chk("sda0", {pinOe[0], pinOut[0]}, 32'h2);
    chk("scl1", pinOe[1], 32'h0);
    $display("test crossbar done");
  endtask

  task automatic t_memif;
    wr(8'h2C, 8'h42);
    memif <= '{1'b1, 1'b0, 1'b0, 32'h88, 32'h08, 32'h0};
    settle(3);
    chk("mem out", {pinOe[7], pinOut[7]}, 32'h2);
    @(posedge sys_clk);
    memif.readXfer <= 1'b1;
    settle(2);
    chk("mem rd", {pinOe[7], pinOe[3]}, 32'h2);
    @(posedge sys_clk);
    memif.active <= 1'b0;
    settle(2);
    chk("mem off", pinOut[7], 32'h1);
    $display("test memif done");
  endtask

  task automatic t_edge;
    // pin 30 idles high; drop it first so a real rise can follow
    @(posedge sys_clk);
    extVal[30] <= 1'b0;
    wr(8'h30, 8'h03);
    wr(8'h24, 8'h04);
    extVal[30] <= 1'b1;
    settle(4);
    chk("rise a", edgeIrqReq, 32'h1);
    @(posedge sys_clk);
    extVal[31] <= 1'b0;
    settle(4);
    chk("fall b", edgeIrqReq, 32'h3);
    rdc("irq reg", 8'h24, 32'hC4);
    wr(8'h24, 8'h04);
    extVal[30] <= 1'b0;
    settle(5);
    chk("cleared", edgeIrqReq, 32'h0);
    wr(8'h30, 8'h00);
    extVal[30] <= 1'b1;
    settle(5);
    chk("masked", edgeIrqReq, 32'h0);
    wr(8'h30, 8'h01);
    settle(1);
    chk("unmasked", edgeIrqReq, 32'h1);
    $display("test edge done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    spiMaster = 1'b1;
    periphOut = 6'h3F;
    memif = '0;
    extEn = 32'hC0000000;
    extVal = 32'hC0000000;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset;
    t_gpio;
    t_analog;
    t_xbar;
    t_memif;
    t_edge;
    wrap_up;
  end
endmodule
`default_nettype wire
